// *** baf_regs.vh ***
// Function
// - best effort frames judged on buffer occupancy and destination queue state
// - drop frame when source port lacks space for it
// - congested queue and empty shared pool drop at programmable percentage
// - congested queue and reservation below low threshold drop frame
// - flow control capable source ports skip the percentage and low threshold drops, not the no-space drop
// - flow control enabled: pause source port when its space is scarce
// - priority classification kept for ports without flow control; queues below top still see early discard
// - unicast pause once programmed count of reserved slots is used
// - release unicast pause when all reserved slots are freed or when flow control is disabled
// - single frame within reservation never pauses a port while the pause threshold is two or more
// - global multicast counter pauses when above programmed threshold
// - multicast pause released when count falls below threshold
// - four queues: top management/expedited, middle assured, lowest best effort
// - best effort queue served only when higher queues empty
// - traffic from flow control ports treated as best effort
// - admitted management and expedited frames never dropped
// - programmable priority map applies to ports without flow control; flow control ports forced to best effort
// - allocate in class section, then shared pool, then port reservation
`ifndef BAF_REGS_VH
`define BAF_REGS_VH
`define BAF_NPORTS 10
`define BAF_PORT_W 4
`define BAF_CNT_W 10
`define BAF_PRIO_W 3
`define BAF_Q_W 2
`define BAF_Q_BE 2'h0
`define BAF_Q_TOP 2'h3
`define BAF_AREA_CLASS 2'h0
`define BAF_AREA_SHARED 2'h1
`define BAF_AREA_PORT 2'h2
`define BAF_AREA_NONE 2'h3
`define BAF_MAP_RESET 16'hFA50
`define BAF_XOFF_RESET 10'h002
`define BAF_MCTH_RESET 10'h3FF
`define BAF_LFSR_SEED 16'hACE1
`define BAF_ADDR_W 4
`define BAF_REG_CTRL 4'h0
`define BAF_REG_RATE 4'h1
`define BAF_REG_LOWTH 4'h2
`define BAF_REG_XOFF 4'h3
`define BAF_REG_MCTH 4'h4
`define BAF_REG_FCPORTS 4'h5
`define BAF_REG_MAP 4'h6
`define BAF_REG_STAT 4'h7
`define BAF_REG_CLR 4'h8
`define BAF_REG_IEN 4'h9
`define BAF_REG_PAUSE 4'hA
`define BAF_REG_MCCNT 4'hB
`define BAF_REG_RSV 4'hC
`define BAF_REG_SHFREE 4'hD
`define BAF_EV_DROP 0
`define BAF_EV_XOFF 1
`define BAF_EV_XON 2
`define BAF_EV_MCXOFF 3
`define BAF_EV_MCXON 4
`define BAF_NEV 5
`endif

// *** baf_lfsr.v ***
`timescale 1ns/1ps
`include "baf_regs.vh"
module baf_lfsr (
  clk,
  reset,
  rnd
);
  input wire clk;
  input wire reset;
  output wire [6:0] rnd;
  reg [15:0] lfsr_reg;
  // free running source for percentage drop
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      lfsr_reg <= `BAF_LFSR_SEED;
    end else begin
      lfsr_reg <= {lfsr_reg[14:0], lfsr_reg[15] ^ lfsr_reg[13] ^ lfsr_reg[12] ^ lfsr_reg[10]};
    end
  end
  assign rnd = lfsr_reg[6:0];
endmodule // baf_lfsr

// *** baf_sched.v ***
`timescale 1ns/1ps
`include "baf_regs.vh"
module baf_sched (
  q_nonempty,
  grant
);
  input wire [3:0] q_nonempty;
  output reg [3:0] grant;
  // strict priority, lowest queue only when all above empty
  always @* begin
    grant = 4'h0;
    if (q_nonempty[3]) begin
      grant = 4'h8;
    end else if (q_nonempty[2]) begin
      grant = 4'h4;
    end else if (q_nonempty[1]) begin
      grant = 4'h2;
    end else if (q_nonempty[0]) begin
      grant = 4'h1;
    end
  end
endmodule // baf_sched

// *** baf_admit.v ***
`timescale 1ns/1ps
`include "baf_regs.vh"
module baf_admit (
  clk,
  reset,
  addr,
  wdata,
  wr,
  rd,
  rdata,
  frm_valid,
  frm_port,
  frm_prio,
  frm_mcast,
  frm_q_congested,
  frm_wred_drop,
  class_full,
  shared_free,
  rsv_size_flat,
  dec_valid,
  dec_drop,
  dec_queue,
  dec_area,
  rel_valid,
  rel_port,
  rel_area,
  rel_mcast,
  q_nonempty,
  q_grant,
  pause,
  mc_pause,
  irq
);
  input wire clk;
  input wire reset;
  input wire [3:0] addr;
  input wire [15:0] wdata;
  input wire wr;
  input wire rd;
  output reg [15:0] rdata;
  input wire frm_valid;
  input wire [3:0] frm_port;
  input wire [2:0] frm_prio;
  input wire frm_mcast;
  input wire frm_q_congested;
  input wire frm_wred_drop;
  input wire class_full;
  input wire [9:0] shared_free;
  input wire [99:0] rsv_size_flat;
  output reg dec_valid;
  output reg dec_drop;
  output reg [1:0] dec_queue;
  output reg [1:0] dec_area;
  input wire rel_valid;
  input wire [3:0] rel_port;
  input wire [1:0] rel_area;
  input wire rel_mcast;
  input wire [3:0] q_nonempty;
  output reg [3:0] q_grant;
  output reg [9:0] pause;
  output reg mc_pause;
  output reg irq;

  reg ctrl_fc_en_reg;
  reg [6:0] rate_reg;
  reg [9:0] lowth_reg;
  reg [9:0] xoff_reg;
  reg [9:0] mcth_reg;
  reg [9:0] fcports_reg;
  reg [15:0] map_reg;
  reg [4:0] stat_reg;
  reg [4:0] ien_reg;
  reg [9:0] mccnt_reg;
  reg [9:0] rsv_used [0:9];
  reg [9:0] pause_next;
  reg mc_pause_next;
  reg [4:0] ev;
  reg [9:0] my_rsv;
  reg [9:0] my_used;
  reg [9:0] rsv_left;
  reg [1:0] q_sel;
  reg [1:0] area;
  reg drop;
  reg fc_port;
  wire [6:0] rnd;
  wire [3:0] grant_w;
  integer i;
  integer j;
  integer k;
  reg port_ok;
  reg [9:0] alloc_hit;
  reg [9:0] free_hit;
  reg mc_alloc;
  reg mc_free;

  function [9:0] rsv_of;
    input [99:0] flat;
    input [3:0] p;
    begin
      rsv_of = flat[p*10 +: 10];
    end
  endfunction

  // stops at zero so a stray release cannot wrap a count
  function [9:0] cnt_step;
    input [9:0] cnt;
    input up;
    input down;
    begin
      cnt_step = cnt;
      if (up) begin
        cnt_step = cnt_step + 10'h001;
      end
      if (down && cnt != 10'h000) begin
        cnt_step = cnt_step - 10'h001;
      end
    end
  endfunction

  function [1:0] queue_of;
    input [15:0] map;
    input [2:0] prio;
    begin
      queue_of = map[prio[2:1]*4 +: 2];
    end
  endfunction

  baf_lfsr u_lfsr (
    .clk(clk),
    .reset(reset),
    .rnd(rnd)
  );

  baf_sched u_sched (
    .q_nonempty(q_nonempty),
    .grant(grant_w)
  );

  // admission decision for one frame
  always @* begin
    port_ok = frm_port < 4'hA;
    if (port_ok) begin
      fc_port = fcports_reg[frm_port];
      my_rsv = rsv_of(rsv_size_flat, frm_port);
      my_used = rsv_used[frm_port];
    end else begin
      fc_port = 1'b0;
      my_rsv = 10'h000;
      my_used = 10'h000;
    end
    // a shrunk reservation must not wrap into a huge remainder
    if (my_used > my_rsv) begin
      rsv_left = 10'h000;
    end else begin
      rsv_left = my_rsv - my_used;
    end
    // map applies to ports without flow control, classes go in pairs
    q_sel = queue_of(map_reg, frm_prio);
    if (fc_port) begin
      q_sel = `BAF_Q_BE;
    end
    // class section, shared pool, then reservation
    if (!class_full && frm_prio[2:1] != 2'h0) begin
      area = `BAF_AREA_CLASS;
    end else if (shared_free != 10'h000) begin
      area = `BAF_AREA_SHARED;
    end else if (rsv_left != 10'h000) begin
      area = `BAF_AREA_PORT;
    end else begin
      area = `BAF_AREA_NONE;
    end
    drop = 1'b0;
    if (q_sel != `BAF_Q_TOP) begin
      drop = frm_wred_drop;
    end
    if (q_sel == `BAF_Q_BE && !fc_port) begin
      if (area == `BAF_AREA_NONE) begin
        drop = 1'b1;
      end
      if (frm_q_congested && shared_free == 10'h000 && rnd < rate_reg) begin
        drop = 1'b1;
      end
      if (frm_q_congested && rsv_left < lowth_reg) begin
        drop = 1'b1;
      end
    end
    if (area == `BAF_AREA_NONE) begin
      drop = 1'b1;
    end
    // no such port: never let it take a slot
    if (!port_ok) begin
      drop = 1'b1;
    end
  end

  // per-port count steps
  always @* begin
    alloc_hit = 10'h000;
    free_hit = 10'h000;
    for (j = 0; j < 10; j = j + 1) begin
      alloc_hit[j] = frm_valid && !drop && area == `BAF_AREA_PORT && frm_port == j;
      free_hit[j] = rel_valid && rel_area == `BAF_AREA_PORT && rel_port == j;
    end
    mc_alloc = frm_valid && !drop && frm_mcast;
    mc_free = rel_valid && rel_mcast;
  end

  // pause evaluation from live counts
  always @* begin
    for (i = 0; i < 10; i = i + 1) begin
      pause_next[i] = pause[i];
      // a single frame stays below a threshold of two or more
      if (ctrl_fc_en_reg && rsv_used[i] >= xoff_reg && xoff_reg != 10'h000) begin
        pause_next[i] = 1'b1;
      end else if (pause[i] && rsv_used[i] == 10'h000) begin
        pause_next[i] = 1'b0;
      end
      if (!ctrl_fc_en_reg) begin
        pause_next[i] = 1'b0;
      end
    end
  end

  // multicast pause holds while the count sits on the threshold
  always @* begin
    mc_pause_next = mc_pause;
    if (mccnt_reg > mcth_reg) begin
      mc_pause_next = 1'b1;
    end else if (mccnt_reg < mcth_reg) begin
      mc_pause_next = 1'b0;
    end
  end

  // event strobes for the status bits
  always @* begin
    ev = 5'h00;
    ev[`BAF_EV_DROP] = frm_valid && drop;
    ev[`BAF_EV_XOFF] = |(pause_next & ~pause);
    ev[`BAF_EV_XON] = |(~pause_next & pause);
    ev[`BAF_EV_MCXOFF] = mc_pause_next && !mc_pause;
    ev[`BAF_EV_MCXON] = !mc_pause_next && mc_pause;
  end

  // counters updated on allocation and release
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      for (k = 0; k < 10; k = k + 1) begin
        rsv_used[k] <= 10'h000;
      end
      mccnt_reg <= 10'h000;
    end else begin
      // only slots taken from the reservation itself count per port
      for (k = 0; k < 10; k = k + 1) begin
        rsv_used[k] <= cnt_step(rsv_used[k], alloc_hit[k], free_hit[k]);
      end
      mccnt_reg <= cnt_step(mccnt_reg, mc_alloc, mc_free);
    end
  end

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      dec_valid <= 1'b0;
      dec_drop <= 1'b0;
      dec_queue <= 2'h0;
      dec_area <= 2'h0;
      q_grant <= 4'h0;
      pause <= 10'h000;
      mc_pause <= 1'b0;
      irq <= 1'b0;
    end else begin
      dec_valid <= frm_valid;
      dec_drop <= frm_valid && drop;
      dec_queue <= q_sel;
      dec_area <= area;
      q_grant <= grant_w;
      pause <= pause_next;
      mc_pause <= mc_pause_next;
      irq <= |(stat_reg & ien_reg);
    end
  end

  // register writes; read-only and unmapped addresses are ignored
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      ctrl_fc_en_reg <= 1'b0;
      rate_reg <= 7'h00;
      lowth_reg <= 10'h000;
      xoff_reg <= `BAF_XOFF_RESET;
      mcth_reg <= `BAF_MCTH_RESET;
      fcports_reg <= 10'h000;
      map_reg <= `BAF_MAP_RESET;
      ien_reg <= 5'h00;
    end else if (wr) begin
      case (addr)
        `BAF_REG_CTRL: ctrl_fc_en_reg <= wdata[0];
        `BAF_REG_RATE: rate_reg <= wdata[6:0];
        `BAF_REG_LOWTH: lowth_reg <= wdata[9:0];
        `BAF_REG_XOFF: xoff_reg <= wdata[9:0];
        `BAF_REG_MCTH: mcth_reg <= wdata[9:0];
        `BAF_REG_FCPORTS: fcports_reg <= wdata[9:0];
        `BAF_REG_MAP: map_reg <= wdata;
        `BAF_REG_IEN: ien_reg <= wdata[4:0];
        default: ;
      endcase
    end
  end

  // status bits: set beats clear in the same cycle
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      stat_reg <= 5'h00;
    end else if (wr && addr == `BAF_REG_CLR) begin
      stat_reg <= (stat_reg & ~wdata[4:0]) | ev;
    end else begin
      stat_reg <= stat_reg | ev;
    end
  end

  // read data stands one cycle, zero otherwise
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      rdata <= 16'h0000;
    end else if (rd) begin
      case (addr)
        `BAF_REG_CTRL: rdata <= {15'h0000, ctrl_fc_en_reg};
        `BAF_REG_RATE: rdata <= {9'h000, rate_reg};
        `BAF_REG_LOWTH: rdata <= {6'h00, lowth_reg};
        `BAF_REG_XOFF: rdata <= {6'h00, xoff_reg};
        `BAF_REG_MCTH: rdata <= {6'h00, mcth_reg};
        `BAF_REG_FCPORTS: rdata <= {6'h00, fcports_reg};
        `BAF_REG_MAP: rdata <= map_reg;
        `BAF_REG_STAT: rdata <= {11'h000, stat_reg};
        `BAF_REG_IEN: rdata <= {11'h000, ien_reg};
        `BAF_REG_PAUSE: rdata <= {5'h00, mc_pause, pause};
        `BAF_REG_MCCNT: rdata <= {6'h00, mccnt_reg};
        `BAF_REG_RSV: rdata <= {6'h00, rsv_used[wdata[3:0] % 10]};
        `BAF_REG_SHFREE: rdata <= {6'h00, shared_free};
        default: rdata <= 16'h0000;
      endcase
    end else begin
      rdata <= 16'h0000;
    end
  end
endmodule // baf_admit

// *** baf_admit_properties.sv ***
`timescale 1ns/1ps
module baf_chk (
  input wire clk,
  input wire reset,
  input wire wr,
  input wire frm_valid,
  input wire rel_valid,
  input wire dec_valid,
  input wire dec_drop,
  input wire [1:0] dec_queue,
  input wire [1:0] dec_area,
  input wire [3:0] q_nonempty,
  input wire [3:0] q_grant,
  input wire [9:0] pause
);
  wire act = frm_valid | wr | rel_valid;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  sequence s_admit; frm_valid ##1 dec_valid; endsequence
  property p_dec; frm_valid |-> s_admit; endproperty
  property p_nodec; !frm_valid |=> !dec_valid; endproperty
  property p_none; dec_valid && dec_area == 2'h3 |-> dec_drop; endproperty
  property p_top; dec_valid && dec_queue == 2'h3 && dec_area != 2'h3 |-> !dec_drop; endproperty
  property p_gtop; q_nonempty[3] |=> q_grant == 4'h8; endproperty
  property p_gbe; q_grant[0] |-> $past(q_nonempty) == 4'h1; endproperty
  property p_gidle; q_nonempty == 4'h0 |=> q_grant == 4'h0; endproperty
  // pause only moves after a frame, a release or a write
  property p_pause;
    $changed(pause) |-> $past(act, 1) || $past(act, 2) || $past(act, 3) || $past(act, 4);
  endproperty
  a_dec: assert property (p_dec) else $error("no decision after frame");
  a_nodec: assert property (p_nodec) else $error("decision without frame");
  a_none: assert property (p_none) else $error("unplaced frame kept");
  a_top: assert property (p_top) else $error("admitted top frame dropped");
  a_gtop: assert property (p_gtop) else $error("top queue not served");
  a_gbe: assert property (p_gbe) else $error("lowest queue served early");
  a_gidle: assert property (p_gidle) else $error("grant with no queue");
  a_pause: assert property (p_pause) else $error("pause moved with no cause");
endmodule // baf_chk
bind baf_admit baf_chk u_chk (.clk(clk), .reset(reset), .wr(wr), .frm_valid(frm_valid),
  .rel_valid(rel_valid), .dec_valid(dec_valid), .dec_drop(dec_drop), .dec_queue(dec_queue),
  .dec_area(dec_area), .q_nonempty(q_nonempty), .q_grant(q_grant), .pause(pause));

// *** baf_qmgr_model.sv ***
`timescale 1ns/1ps
module baf_qmgr (
  input wire clk,
  output logic rel_valid,
  output logic [3:0] rel_port,
  output logic [1:0] rel_area,
  output logic rel_mcast,
  output logic [3:0] q_nonempty
);
  initial begin
    rel_valid = 1'b0;
    rel_port = 4'h0;
    rel_area = 2'h0;
    rel_mcast = 1'b0;
    q_nonempty = 4'h0;
  end
  // one slot back per call; port and area flipped after so stale values never look valid
  task give_back(input logic [3:0] p, input logic [1:0] a, input logic m);
    @(posedge clk);
    rel_valid <= 1'b1;
    rel_port <= p;
    rel_area <= a;
    rel_mcast <= m;
    @(posedge clk);
    rel_valid <= 1'b0;
    rel_port <= ~p;
    rel_area <= ~a;
  endtask
  task queues(input logic [3:0] v);
    @(posedge clk);
    q_nonempty <= v;
  endtask
endmodule // baf_qmgr

// *** baf_admit_test.sv ***
`timescale 1ns/1ps
module baf_admit_test;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic frm_valid = 1'b0;
  logic [3:0] frm_port = 4'h0;
  logic [2:0] frm_prio = 3'h0;
  logic frm_mcast = 1'b0;
  logic frm_cong = 1'b0;
  logic frm_wred = 1'b0;
  logic class_full = 1'b0;
  logic [9:0] shared_free = 10'h005;
  wire [15:0] rdata;
  wire dec_valid, dec_drop, rel_valid, rel_mcast, mc_pause, irq;
  wire [1:0] dec_queue, dec_area, rel_area;
  wire [3:0] rel_port, q_nonempty, q_grant;
  wire [9:0] pause;
  int fail_count = 0;
  int checks_done = 0;
  localparam logic [19:0] q_fill_seq = 20'hF6310;
  localparam logic [19:0] q_grant_seq = 20'h84210;
  always #12.5 clk = ~clk;
  baf_qmgr qm (.clk(clk), .rel_valid(rel_valid), .rel_port(rel_port), .rel_area(rel_area),
    .rel_mcast(rel_mcast), .q_nonempty(q_nonempty));
  // port 1 holds 4 reserved slots, port 3 holds 2, the rest none
  baf_admit DUT (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .frm_valid(frm_valid), .frm_port(frm_port), .frm_prio(frm_prio),
    .frm_mcast(frm_mcast), .frm_q_congested(frm_cong), .frm_wred_drop(frm_wred),
    .class_full(class_full), .shared_free(shared_free), .rsv_size_flat(100'h80001000),
    .dec_valid(dec_valid), .dec_drop(dec_drop), .dec_queue(dec_queue), .dec_area(dec_area),
    .rel_valid(rel_valid), .rel_port(rel_port), .rel_area(rel_area), .rel_mcast(rel_mcast),
    .q_nonempty(q_nonempty), .q_grant(q_grant), .pause(pause), .mc_pause(mc_pause), .irq(irq));
  task chk(input string n, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task rd_chk(input logic [3:0] a, input logic [15:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk("rdata", e, rdata);
  endtask
  // area is only compared for admitted frames
  task frame(input logic [3:0] p, input logic [2:0] pr, input logic m, input logic c,
      input logic ed, input logic [1:0] eq, input logic [1:0] ea);
    @(posedge clk);
    frm_valid <= 1'b1;
    frm_port <= p;
    frm_prio <= pr;
    frm_mcast <= m;
    frm_cong <= c;
    @(posedge clk);
    frm_valid <= 1'b0;
    #1 chk("decision", {12'h0, eq, ed, 1'b1}, {12'h0, dec_queue, dec_drop, dec_valid});
    if (!ed) chk("area", {14'h0, ea}, {14'h0, dec_area});
  endtask
  task settle_pause(input logic [9:0] e, input logic em);
    repeat (3) @(posedge clk);
    #1 chk("pause", {5'h0, em, e}, {5'h0, mc_pause, pause});
  endtask
  task t_reset;
    rd_chk(4'h3, 16'h0002);
    rd_chk(4'h4, 16'h03FF);
    rd_chk(4'h6, 16'hFA50);
    rd_chk(4'hE, 16'h0000);
  endtask
  task t_classes;
    for (int i = 0; i < 4; i++) frame(4'h0, 3'(2 * i + 1), 1'b0, 1'b0, 1'b0, 2'(i), 2'(i == 0));
    for (int i = 0; i < 5; i++) begin
      qm.queues(q_fill_seq[19 - 4 * i -: 4]);
      @(posedge clk);
      #1 chk("grant", {12'h0, q_grant_seq[19 - 4 * i -: 4]}, {12'h0, q_grant});
    end
    wr_reg(4'h6, 16'h0000);
    frame(4'h0, 3'h7, 1'b0, 1'b0, 1'b0, 2'h0, 2'h0);
    wr_reg(4'h6, 16'hFA50);
    frm_wred <= 1'b1;
    frame(4'h0, 3'h5, 1'b0, 1'b0, 1'b1, 2'h2, 2'h0);
    frame(4'h0, 3'h7, 1'b0, 1'b0, 1'b0, 2'h3, 2'h0);
    frm_wred <= 1'b0;
  endtask
  task t_unicast;
    wr_reg(4'h0, 16'h0001);
    class_full <= 1'b1;
    shared_free <= 10'h000;
    frame(4'h1, 3'h0, 1'b0, 1'b0, 1'b0, 2'h0, 2'h2);
    settle_pause(10'h000, 1'b0);
    frame(4'h1, 3'h0, 1'b0, 1'b0, 1'b0, 2'h0, 2'h2);
    settle_pause(10'h002, 1'b0);
    qm.give_back(4'h1, 2'h2, 1'b0);
    settle_pause(10'h002, 1'b0);
    qm.give_back(4'h1, 2'h2, 1'b0);
    settle_pause(10'h000, 1'b0);
  endtask
  task t_drops;
    frame(4'h2, 3'h0, 1'b0, 1'b0, 1'b1, 2'h0, 2'h3);
    wr_reg(4'h2, 16'h0004);
    frame(4'h1, 3'h0, 1'b0, 1'b1, 1'b0, 2'h0, 2'h2);
    qm.give_back(4'h1, 2'h2, 1'b0);
    frame(4'h3, 3'h0, 1'b0, 1'b1, 1'b1, 2'h0, 2'h2);
    wr_reg(4'h5, 16'h0008);
    frame(4'h3, 3'h4, 1'b0, 1'b1, 1'b0, 2'h0, 2'h2);
  endtask
  task t_mcast;
    shared_free <= 10'h005;
    wr_reg(4'h4, 16'h0001);
    frame(4'h4, 3'h0, 1'b1, 1'b0, 1'b0, 2'h0, 2'h1);
    settle_pause(10'h000, 1'b0);
    frame(4'h4, 3'h0, 1'b1, 1'b0, 1'b0, 2'h0, 2'h1);
    settle_pause(10'h000, 1'b1);
    qm.give_back(4'h4, 2'h1, 1'b1);
    settle_pause(10'h000, 1'b1);
    qm.give_back(4'h4, 2'h1, 1'b1);
    settle_pause(10'h000, 1'b0);
  endtask
  task t_irq;
    rd_chk(4'h7, 16'h001F);
    wr_reg(4'h9, 16'h0001);
    repeat (2) @(posedge clk);
    #1 chk("irq", 16'h0001, {15'h0, irq});
    wr_reg(4'h9, 16'h0000);
    repeat (2) @(posedge clk);
    #1 chk("irq", 16'h0000, {15'h0, irq});
    wr_reg(4'h9, 16'h001F);
    wr_reg(4'h8, 16'h001F);
    rd_chk(4'h7, 16'h0000);
    #1 chk("irq", 16'h0000, {15'h0, irq});
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    t_reset;
    t_classes;
    t_unicast;
    t_drops;
    t_mcast;
    t_irq;
    close_out;
  end
  initial begin
    #100000;
    fail_count++;
    close_out;
  end
endmodule // baf_admit_test
